// file: hw/fcs_host.sv
// Flash command sequencer host: APB registers driving a parallel flash
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"

module fcs_host
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash bus
   output logic flashCeN,
   output logic flashOeN,
   output logic flashWeN,
   output logic [16:0] flashAddr,
   output logic [7:0] flashDqOut,
   output logic flashDqOe,
   input wire logic [7:0] flashDqIn
);

   typedef struct packed {
      fcs_pkg::fcs_mstate_t st;
      fcs_pkg::fcs_op_t op;
      logic [2:0] step;
      logic [16:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [7:0] first;
      logic busy;
      logic done;
      logic fail;
      logic refused;
      logic winOpen;
      logic [11:0] winCnt;
      logic erasing;
      logic susp;
      logic start;
      logic isWr;
      fcs_pkg::fcs_step_t bus;
      logic [31:0] prdata;
   } fcs_main_state_t;

   fcs_main_state_t s_q, s_d;
   fcs_pkg::fcs_pins_t pins;
   logic bDone;
   logic [7:0] bRdata;
   logic apbWr;
   logic apbSetup;
   logic mapped;
   logic pass;
   logic allow;

   // Unlock-prefixed command address on the low eleven bits
   function automatic logic [16:0] cmdAdr(input logic [10:0] low);
      cmdAdr = {6'h00, low};
   endfunction

   // Number of write cycles of each operation
   function automatic logic [2:0] seqLen(input fcs_pkg::fcs_op_t op);
      case (op)
         fcs_pkg::OP_ID, fcs_pkg::OP_PVER: seqLen = 3'd3;
         fcs_pkg::OP_PROG: seqLen = 3'd4;
         fcs_pkg::OP_CHIP, fcs_pkg::OP_SECT, fcs_pkg::OP_PUNL: seqLen = 3'd6;
         default: seqLen = 3'd1;
      endcase
   endfunction

   // Address and data of one write cycle of an operation
   function automatic fcs_pkg::fcs_step_t seqStep(input fcs_pkg::fcs_op_t op, input logic [2:0] idx,
                                                 input logic [16:0] a, input logic [7:0] d);
      fcs_pkg::fcs_step_t r;
      r.addr = cmdAdr(`FCS_ADR_UNLOCK1);
      r.data = `FCS_DAT_UNLOCK1;
      case (op)
         fcs_pkg::OP_RESET: r = '{addr: a, data: `FCS_DAT_RESET};
         fcs_pkg::OP_SUSP: r = '{addr: a, data: `FCS_DAT_SUSPEND};
         fcs_pkg::OP_RESUM: r = '{addr: a, data: `FCS_DAT_RESUME};
         fcs_pkg::OP_ADDS: r = '{addr: a, data: `FCS_DAT_SECTOR};
         default:
         begin
            case (idx)
               3'd1, 3'd4: r = '{addr: cmdAdr(`FCS_ADR_UNLOCK2), data: `FCS_DAT_UNLOCK2};
               3'd2:
               begin
                  case (op)
                     fcs_pkg::OP_ID, fcs_pkg::OP_PVER: r.data = `FCS_DAT_ID;
                     fcs_pkg::OP_PROG: r.data = `FCS_DAT_PROG;
                     default: r.data = `FCS_DAT_SETUP;
                  endcase
               end
               3'd3: if (op == fcs_pkg::OP_PROG) r = '{addr: a, data: d};
               3'd5:
               begin
                  case (op)
                     fcs_pkg::OP_CHIP: r.data = `FCS_DAT_CHIP;
                     fcs_pkg::OP_PUNL: r.data = `FCS_DAT_PUNLOCK;
                     default: r = '{addr: a, data: `FCS_DAT_SECTOR};
                  endcase
               end
               default: r = r;
            endcase
         end
      endcase
      seqStep = r;
   endfunction

   // Read address after identification or protection verify
   function automatic logic [16:0] rdAdr(input fcs_pkg::fcs_op_t op, input logic [16:0] a);
      case (op)
         fcs_pkg::OP_ID: rdAdr = {a[16:2], 1'b0, a[0]};
         fcs_pkg::OP_PVER: rdAdr = {a[16:2], 2'b10};
         default: rdAdr = a;
      endcase
   endfunction

   // APB decode
   assign apbWr = psel & penable & pwrite;
   assign apbSetup = psel & ~penable;
   assign mapped = (paddr == `FCS_REG_CMD) | (paddr == `FCS_REG_ADDR) | (paddr == `FCS_REG_WDATA) |
                   (paddr == `FCS_REG_STATUS) | (paddr == `FCS_REG_RDATA);
   assign pass = (s_q.op == fcs_pkg::OP_PROG) ? (bRdata[`FCS_POLL_BIT] == s_q.wdata[`FCS_POLL_BIT]) :
                 bRdata[`FCS_POLL_BIT];

   // Command acceptance policy
   always_comb
   begin
      allow = 1'b1;
      case (fcs_pkg::fcs_op_t'(pwdata[3:0]))
         fcs_pkg::OP_ADDS: allow = s_q.winOpen & ~s_q.susp;
         fcs_pkg::OP_SUSP: allow = s_q.erasing & ~s_q.susp;
         fcs_pkg::OP_RESUM: allow = s_q.susp;
         fcs_pkg::OP_READ, fcs_pkg::OP_PROG, fcs_pkg::OP_POLL: allow = 1'b1;
         fcs_pkg::OP_RESET, fcs_pkg::OP_ID, fcs_pkg::OP_PVER, fcs_pkg::OP_CHIP, fcs_pkg::OP_SECT,
         fcs_pkg::OP_PUNL: allow = ~s_q.susp;
         default: allow = 1'b0;
      endcase
   end

   // Sequencer, window timer and registers
   always_comb
   begin
      s_d = s_q;
      s_d.start = 1'b0;
      // Load window counts down after each sector write
      if (s_q.winOpen)
      begin
         if (s_q.winCnt == 12'h000)
         begin
            s_d.winOpen = 1'b0;
         end
         else
         begin
            s_d.winCnt = s_q.winCnt - 12'h001;
         end
      end
      // Read data captured in the setup phase
      if (apbSetup)
      begin
         case (paddr)
            `FCS_REG_ADDR: s_d.prdata = {15'h0000, s_q.addr};
            `FCS_REG_WDATA: s_d.prdata = {24'h000000, s_q.wdata};
            `FCS_REG_STATUS: s_d.prdata = {25'h0000000, s_q.erasing, s_q.susp, s_q.winOpen, s_q.refused,
                                          s_q.fail, s_q.done, s_q.busy};
            `FCS_REG_RDATA: s_d.prdata = {24'h000000, s_q.rdata};
            default: s_d.prdata = 32'h00000000;
         endcase
      end
      // Register writes
      if (apbWr && !s_q.busy)
      begin
         if (paddr == `FCS_REG_ADDR)
            s_d.addr = pwdata[16:0];
         if (paddr == `FCS_REG_WDATA)
            s_d.wdata = pwdata[7:0];
         if (paddr == `FCS_REG_CMD)
         begin
            s_d.op = fcs_pkg::fcs_op_t'(pwdata[3:0]);
            s_d.done = 1'b0;
            s_d.fail = 1'b0;
            s_d.refused = ~allow;
            s_d.step = 3'd0;
            if (!allow)
            begin
               s_d.done = 1'b1;
            end
            else
            begin
               s_d.busy = 1'b1;
               // Any accepted command but another sector value ends the window
               if (s_d.op != fcs_pkg::OP_ADDS)
                  s_d.winOpen = 1'b0;
               if (s_d.op == fcs_pkg::OP_SUSP)
                  s_d.susp = 1'b1;
               if (s_d.op == fcs_pkg::OP_RESUM)
                  s_d.susp = 1'b0;
               if (s_d.op == fcs_pkg::OP_RESET)
                  s_d.erasing = 1'b0;
               s_d.start = 1'b1;
               if (s_d.op == fcs_pkg::OP_READ)
               begin
                  s_d.isWr = 1'b0;
                  s_d.bus = '{addr: s_q.addr, data: 8'h00};
                  s_d.st = fcs_pkg::M_RD;
               end
               else if (s_d.op == fcs_pkg::OP_POLL)
               begin
                  s_d.isWr = 1'b0;
                  s_d.bus = '{addr: s_q.addr, data: 8'h00};
                  s_d.st = fcs_pkg::M_P1;
               end
               else
               begin
                  s_d.isWr = 1'b1;
                  s_d.bus = seqStep(s_d.op, 3'd0, s_q.addr, s_q.wdata);
                  s_d.st = fcs_pkg::M_WR;
               end
            end
         end
      end
      case (s_q.st)
         fcs_pkg::M_IDLE:
         begin
            s_d.busy = s_d.busy;
         end
         fcs_pkg::M_WR:
         begin
            if (bDone)
            begin
               if (s_q.step == seqLen(s_q.op) - 3'd1)
               begin
                  s_d.start = 1'b1;
                  s_d.isWr = 1'b0;
                  s_d.bus = '{addr: rdAdr(s_q.op, s_q.addr), data: 8'h00};
                  case (s_q.op)
                     fcs_pkg::OP_SECT, fcs_pkg::OP_ADDS:
                     begin
                        // Window timed from the rising strobe
                        s_d.winOpen = 1'b1;
                        // Margin so an accepted load still falls inside the window
                        s_d.winCnt = 12'(`FCS_WIN_CYC - `FCS_RECOV_CYC - 4);
                        s_d.erasing = 1'b1;
                        s_d.start = 1'b0;
                        s_d.st = fcs_pkg::M_IDLE;
                     end
                     fcs_pkg::OP_ID, fcs_pkg::OP_PVER: s_d.st = fcs_pkg::M_RD;
                     fcs_pkg::OP_PROG, fcs_pkg::OP_CHIP: s_d.st = fcs_pkg::M_P1;
                     default:
                     begin
                        s_d.start = 1'b0;
                        s_d.st = fcs_pkg::M_IDLE;
                     end
                  endcase
                  if (s_d.st == fcs_pkg::M_IDLE)
                  begin
                     s_d.busy = 1'b0;
                     s_d.done = 1'b1;
                  end
               end
               else
               begin
                  s_d.step = s_q.step + 3'd1;
                  s_d.start = 1'b1;
                  s_d.bus = seqStep(s_q.op, s_d.step, s_q.addr, s_q.wdata);
               end
            end
         end
         fcs_pkg::M_RD:
         begin
            if (bDone)
            begin
               s_d.rdata = bRdata;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.st = fcs_pkg::M_IDLE;
            end
         end
         fcs_pkg::M_P1:
         begin
            if (bDone)
            begin
               s_d.first = bRdata;
               s_d.start = 1'b1;
               s_d.st = fcs_pkg::M_P2;
            end
         end
         fcs_pkg::M_P2:
         begin
            if (bDone)
            begin
               s_d.rdata = bRdata;
               if (bRdata[`FCS_TOGGLE_BIT] == s_q.first[`FCS_TOGGLE_BIT])
               begin
                  // Toggle steady over two reads: finished
                  s_d.busy = 1'b0;
                  s_d.done = 1'b1;
                  s_d.fail = ~pass;
                  if (s_q.op != fcs_pkg::OP_PROG)
                     s_d.erasing = 1'b0;
                  s_d.st = fcs_pkg::M_IDLE;
               end
               else if (bRdata[`FCS_TIMEOUT_FLAG])
               begin
                  // Over time limit: abort with reset value
                  s_d.fail = 1'b1;
                  s_d.erasing = 1'b0;
                  s_d.isWr = 1'b1;
                  s_d.bus = '{addr: s_q.addr, data: `FCS_DAT_RESET};
                  s_d.start = 1'b1;
                  s_d.st = fcs_pkg::M_ABRT;
               end
               else
               begin
                  s_d.start = 1'b1;
                  s_d.st = fcs_pkg::M_P1;
               end
            end
         end
         fcs_pkg::M_ABRT:
         begin
            if (bDone)
            begin
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.st = fcs_pkg::M_IDLE;
            end
         end
         default:
         begin
            s_d.st = fcs_pkg::M_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         s_q <= '0;
         s_q.st <= fcs_pkg::M_IDLE;
         s_q.op <= fcs_pkg::OP_READ;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   fcs_bus_cycle u_bus
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .start(s_q.start),
      .isWrite(s_q.isWr),
      .addr(s_q.bus.addr),
      .wdata(s_q.bus.data),
      .done(bDone),
      .rdata(bRdata),
      .pins(pins),
      .dqIn(flashDqIn)
   );

   // Outputs
   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign flashCeN = pins.ceN;
   assign flashOeN = pins.oeN;
   assign flashWeN = pins.weN;
   assign flashAddr = pins.addr;
   assign flashDqOut = pins.dqOut;
   assign flashDqOe = pins.dqOe;

endmodule
`default_nettype wire

// file: hw/fcs_cfg.svh
// Constants of the flash command sequencer host: offsets, codes, timing
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// Clock rate and flash bus timing
`define FCS_CLK_MHZ 100
`define FCS_T_STROBE_NS 100
`define FCS_T_RECOV_NS 50
`define FCS_T_WIN_US 30
`define FCS_STROBE_CYC ((`FCS_T_STROBE_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_RECOV_CYC ((`FCS_T_RECOV_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_WIN_CYC (`FCS_T_WIN_US * `FCS_CLK_MHZ)

// Register offsets
`define FCS_REG_CMD 8'h00
`define FCS_REG_ADDR 8'h04
`define FCS_REG_WDATA 8'h08
`define FCS_REG_STATUS 8'h0c
`define FCS_REG_RDATA 8'h10

// Status field positions
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_REFUSED 3
`define FCS_ST_WINOPEN 4
`define FCS_ST_SUSP 5
`define FCS_ST_ERASING 6

// Unlock addresses and command values
`define FCS_ADR_UNLOCK1 11'h555
`define FCS_ADR_UNLOCK2 11'h2aa
`define FCS_DAT_UNLOCK1 8'haa
`define FCS_DAT_UNLOCK2 8'h55
`define FCS_DAT_RESET 8'hf0
`define FCS_DAT_ID 8'h90
`define FCS_DAT_PROG 8'ha0
`define FCS_DAT_SETUP 8'h80
`define FCS_DAT_CHIP 8'h10
`define FCS_DAT_SECTOR 8'h30
`define FCS_DAT_SUSPEND 8'hb0
`define FCS_DAT_RESUME 8'h30
`define FCS_DAT_PUNLOCK 8'h20

// Status bit positions on the flash data bus
`define FCS_POLL_BIT 7
`define FCS_TOGGLE_BIT 6
`define FCS_TIMEOUT_FLAG 5

`endif

// file: hw/fcs_pkg.sv
// Types of the flash command sequencer host
`default_nettype none
package fcs_pkg;

   typedef enum logic [3:0] {
      OP_READ = 4'h0, OP_RESET = 4'h1, OP_ID = 4'h2, OP_PVER = 4'h3,
      OP_PROG = 4'h4, OP_CHIP = 4'h5, OP_SECT = 4'h6, OP_ADDS = 4'h7,
      OP_SUSP = 4'h8, OP_RESUM = 4'h9, OP_PUNL = 4'ha, OP_POLL = 4'hb
   } fcs_op_t;

   typedef enum logic [3:0] {
      B_IDLE = 4'b0001, B_SETUP = 4'b0010, B_STRB = 4'b0100, B_RECV = 4'b1000
   } fcs_bstate_t;

   typedef enum logic [5:0] {
      M_IDLE = 6'b000001, M_WR = 6'b000010, M_RD = 6'b000100,
      M_P1 = 6'b001000, M_P2 = 6'b010000, M_ABRT = 6'b100000
   } fcs_mstate_t;

   // Flash pin outputs
   typedef struct packed {
      logic ceN;
      logic oeN;
      logic weN;
      logic [16:0] addr;
      logic [7:0] dqOut;
      logic dqOe;
   } fcs_pins_t;

   // One command bus cycle
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] data;
   } fcs_step_t;

   // Bus cycle engine state
   typedef struct packed {
      fcs_bstate_t st;
      logic [7:0] cnt;
      fcs_pins_t pins;
      logic [7:0] rdata;
      logic done;
   } fcs_bus_state_t;

endpackage
`default_nettype wire

// file: hw/fcs_bus_cycle.sv
// One read or write cycle on the asynchronous flash bus
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"

module fcs_bus_cycle
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Request
   input wire logic start,
   input wire logic isWrite,
   input wire logic [16:0] addr,
   input wire logic [7:0] wdata,
   // Answer
   output logic done,
   output logic [7:0] rdata,
   // Flash pins
   output fcs_pkg::fcs_pins_t pins,
   input wire logic [7:0] dqIn
);

   fcs_pkg::fcs_bus_state_t s_q, s_d;

   // Cycle sequencing: setup, strobe low, recovery
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         fcs_pkg::B_IDLE:
         begin
            if (start)
            begin
               s_d.pins.ceN = 1'b0;
               s_d.pins.addr = addr;
               s_d.pins.dqOut = wdata;
               s_d.pins.dqOe = isWrite; // Drive only while writing
               s_d.st = fcs_pkg::B_SETUP;
            end
         end
         fcs_pkg::B_SETUP:
         begin
            // Write strobe low with output enable high, or read strobe
            s_d.pins.weN = ~s_q.pins.dqOe;
            s_d.pins.oeN = s_q.pins.dqOe;
            s_d.cnt = 8'(`FCS_STROBE_CYC - 1);
            s_d.st = fcs_pkg::B_STRB;
         end
         fcs_pkg::B_STRB:
         begin
            if (s_q.cnt == 8'h00)
            begin
               s_d.rdata = dqIn;
               s_d.pins.weN = 1'b1;
               s_d.pins.oeN = 1'b1;
               s_d.cnt = 8'(`FCS_RECOV_CYC - 1);
               s_d.st = fcs_pkg::B_RECV;
            end
            else
            begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
         end
         fcs_pkg::B_RECV:
         begin
            if (s_q.cnt == 8'h00)
            begin
               s_d.pins.ceN = 1'b1;
               s_d.pins.dqOe = 1'b0;
               s_d.done = 1'b1;
               s_d.st = fcs_pkg::B_IDLE;
            end
            else
            begin
               s_d.cnt = s_q.cnt - 8'h01;
            end
         end
         default:
         begin
            s_d.st = fcs_pkg::B_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         s_q <= '0;
         s_q.st <= fcs_pkg::B_IDLE;
         s_q.pins.ceN <= 1'b1;
         s_q.pins.oeN <= 1'b1;
         s_q.pins.weN <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign rdata = s_q.rdata;
   assign pins = s_q.pins;

endmodule
`default_nettype wire

// file: tb/fcs_host_asserts.sv
// Concurrent checks on the flash command sequencer host ports
`timescale 1ns/1ns
`default_nettype none
module fcs_host_asserts
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Flash bus
   input wire logic flashCeN,
   input wire logic flashOeN,
   input wire logic flashWeN,
   input wire logic [16:0] flashAddr,
   input wire logic [7:0] flashDqOut,
   input wire logic flashDqOe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // Flash strobes and data drive
   a_dq_write_only: assert property (flashDqOe |-> !flashCeN && flashOeN)
      else $error("dq driven outside a write");
   a_no_contention: assert property (!(!flashOeN && !flashWeN))
      else $error("both strobes low");
   a_write_strobe: assert property ($fell(flashWeN) |->
      (!flashWeN && flashDqOe && $stable(flashAddr))[*8] ##1 !flashWeN[*2] ##1 flashWeN)
      else $error("write strobe width or hold wrong");
   a_read_strobe: assert property ($fell(flashOeN) |-> !flashOeN[*8] ##1 !flashOeN[*2] ##1 flashOeN)
      else $error("read strobe width wrong");
   a_ce_recovery: assert property ($rose(flashWeN) || $rose(flashOeN) |-> !flashCeN[*5] ##1 flashCeN)
      else $error("chip select recovery wrong");
   a_ce_strobe: assert property ($fell(flashCeN) |-> ##1 (!flashWeN || !flashOeN))
      else $error("no strobe after chip select");
   a_unlock_pair: assert property ($fell(flashWeN) && flashDqOut == 8'haa && flashAddr == 17'h555 |->
      ##[1:20] (!flashWeN && flashAddr == 17'h2aa && flashDqOut == 8'h55))
      else $error("second unlock cycle missing");
   a_addr_hold: assert property (!flashCeN && !$past(flashCeN) |->
      $stable(flashAddr) && $stable(flashDqOut))
      else $error("address or data moved inside a cycle");
   // APB answer
   a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
      else $error("unmapped access without error");
endmodule
bind fcs_host fcs_host_asserts i_fcs_host_asserts (.sys_clk, .resetn, .psel, .penable, .paddr, .pready,
   .pslverr, .flashCeN, .flashOeN, .flashWeN, .flashAddr, .flashDqOut, .flashDqOe);
`default_nettype wire

// file: tb/fcs_flash_model.sv
// Behavioural parallel flash that answers the host strobes
`timescale 1ns/1ns
`default_nettype none
module fcs_flash_model
#(
   parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
   parameter logic [7:0] DEVC = 8'h4b, // Arbitrary value
   parameter logic [7:0] PROT = 8'h01
)
(
   // Flash pins
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [16:0] addr,
   input wire logic [7:0] dq,
   output logic [7:0] dqIn,
   // Fault control
   input wire logic failTime
);
   logic [7:0] mem [0:131071];
   logic [16:0] la, sa;
   logic [7:0] pd, last;
   logic tg, idm, susp, pun;
   int n, m, eb, pb;
   initial
   begin
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
      {n, eb, pb} = '0;
      {tg, idm, susp, pun, last} = '0;
   end
   // Sector or whole array set to erased at once; starts the busy count
   task automatic ers(input logic [3:0] s, input logic all);
      for (int i = 0; i < 131072; i++) if (all || 4'(i >> 13) == s) mem[i] = 8'hff;
      eb = 6;
   endtask
   // Address on the falling strobe, sector register on the sixth
   always @(negedge weN)
      if (!ceN)
      begin
         la = addr;
         if (n == 5) sa = addr;
      end
   // Command interpreter on the rising strobe
   always @(posedge weN)
      if (!ceN && oeN)
      begin
         if (n == 9)
         begin
            mem[la] = dq;
            pd = dq;
            pb = 4;
            n = 0;
         end
         else if (dq == 8'hf0)
         begin
            {n, eb, pb} = '0;
            {idm, susp} = '0;
         end
         else if (eb > 0 && dq == 8'h30 && !susp) ers(la[16:13], 0);
         else if (eb > 0 && dq == 8'h30) susp = 0;
         else if (eb > 0 && dq == 8'hb0) susp = 1;
         else if (eb == 0 || susp)
         begin
            m = n;
            n = 0;
            if (m == 0 && dq == 8'haa && la[10:0] == 11'h555) n = 1;
            if (m == 1 && dq == 8'h55 && la[10:0] == 11'h2aa) n = 2;
            if (m == 2 && dq == 8'h90) idm = 1;
            if (m == 2 && dq == 8'ha0) n = 9;
            if (m == 2 && dq == 8'h80) n = 3;
            if (m == 3 && dq == 8'haa) n = 4;
            if (m == 4 && dq == 8'h55) n = 5;
            if (m == 5 && dq == 8'h20) pun = 1;
            if (m == 5 && dq == 8'h10 && !susp) ers(4'h0, 1);
            if (m == 5 && dq == 8'h30 && !susp) ers(sa[16:13], 0);
            if (n == 0 && m != 2) idm = 0;
         end
      end
   // Toggle flips per status read; counts run down after it
   always @(negedge oeN)
      if (!ceN && (pb > 0 || (eb > 0 && !susp))) tg = !tg;
   // Remember what the last read strobe showed
   always @*
      if (!ceN && !oeN && weN) last = dqIn;
   always @(posedge oeN)
   begin
      if (!ceN && pb > 0) pb--;
      else if (!ceN && eb > 0 && !susp && !failTime) eb--;
   end
   // Drive only on a read strobe, otherwise the inverse of the last value
   always @*
      if (ceN || oeN || !weN) dqIn = ~last;
      else if (pb > 0) dqIn = {~pd[7], tg, 6'h0};
      else if (eb > 0 && !susp) dqIn = {1'b0, tg, failTime, 5'h0};
      else if (idm) dqIn = addr[1] ? PROT : addr[0] ? DEVC : MAKER;
      else dqIn = mem[addr];
endmodule
`default_nettype wire

// file: tb/flash_command_sequencer_bench.sv
// Self-checking bench of the flash command sequencer host
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"
module flash_command_sequencer_bench;
   logic sys_clk, resetn, psel, penable, pwrite, pslverr, pready, er, failTime;
   logic [7:0] paddr, flashDqOut, flashDqIn, d;
   logic [31:0] pwdata, prdata, rd, st;
   logic flashCeN, flashOeN, flashWeN, flashDqOe;
   logic [16:0] flashAddr, a, b;
   logic [3:0] ids [3] = '{fcs_pkg::OP_ID, fcs_pkg::OP_ID, fcs_pkg::OP_PVER};
   logic [7:0] idv [3] = '{8'h3c, 8'h4b, 8'h01};
   logic [3:0] rf [3] = '{fcs_pkg::OP_RESUM, fcs_pkg::OP_SUSP, fcs_pkg::OP_ADDS};
   int compares, miscompares;
   // Design and flash model
   fcs_host i_fcs_host (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .flashCeN, .flashOeN, .flashWeN, .flashAddr, .flashDqOut, .flashDqOe, .flashDqIn);
   fcs_flash_model i_fcs_flash_model (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr),
      .dq(flashDqOut), .dqIn(flashDqIn), .failTime);
   // Clock
   always #5 sys_clk = !sys_clk;
   // Expected status word
   function automatic logic [31:0] stv(input logic dn, fl, rj, wo, su);
      return 32'(dn) << `FCS_ST_DONE | 32'(fl) << `FCS_ST_FAIL | 32'(rj) << `FCS_ST_REFUSED
         | 32'(wo) << `FCS_ST_WINOPEN | 32'(su) << `FCS_ST_SUSP;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] r);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   // Command with operands, then wait for busy to clear
   task automatic cmd(input logic [3:0] op, input logic [16:0] ad, input logic [7:0] wd);
      int k;
      apb(1, `FCS_REG_ADDR, {15'h0, ad}, rd);
      apb(1, `FCS_REG_WDATA, {24'h0, wd}, rd);
      apb(1, `FCS_REG_CMD, {28'h0, op}, rd);
      k = 0;
      do apb(0, `FCS_REG_STATUS, 32'h0, st); while (st[`FCS_ST_BUSY] !== 1'b0 && ++k < 2000);
      if (k == 2000) chk(st, 32'h0);
   endtask
   task automatic stc(input logic [31:0] e);
      apb(0, `FCS_REG_STATUS, 32'h0, st);
      chk(st & stv(1, 1, 1, 1, 1), e);
   endtask
   task automatic rdr(input logic [7:0] e);
      apb(0, `FCS_REG_RDATA, 32'h0, rd);
      chk(rd, {24'h0, e});
   endtask
   task automatic rda(input logic [16:0] ad, input logic [7:0] e);
      cmd(fcs_pkg::OP_READ, ad, 8'h0);
      rdr(e);
   endtask
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      repeat (80000) @(posedge sys_clk);
      miscompares++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {sys_clk, resetn, psel, penable, pwrite, paddr, pwdata, failTime} = '0;
      void'($urandom(65463));
      repeat (16) @(posedge sys_clk);
      chk({28'h0, flashCeN, flashOeN, flashWeN, flashDqOe}, 32'he);
      resetn <= 1;
      stc(32'h0);
      repeat (4)
      begin
         a = 17'($urandom);
         d = 8'($urandom);
         cmd(fcs_pkg::OP_PROG, a, d);
         stc(stv(1, 0, 0, 0, 0));
         rda(a, d);
      end
      $display("program test done");
      foreach (ids[i])
      begin
         cmd(ids[i], 17'(i), 8'h0);
         rdr(idv[i]);
      end
      cmd(fcs_pkg::OP_RESET, a, 8'h0);
      rda(a, d);
      cmd(fcs_pkg::OP_PUNL, a, 8'h0);
      stc(stv(1, 0, 0, 0, 0));
      foreach (rf[i])
      begin
         cmd(rf[i], a, 8'h0);
         stc(stv(1, 0, 1, 0, 0));
      end
      $display("id and refusal test done");
      cmd(fcs_pkg::OP_CHIP, a, 8'h0);
      stc(stv(1, 0, 0, 0, 0));
      rda(a, 8'hff);
      $display("chip erase test done");
      b = a ^ 17'h10000;
      cmd(fcs_pkg::OP_PROG, a, 8'h12);
      cmd(fcs_pkg::OP_SECT, a, 8'h0);
      stc(stv(1, 0, 0, 1, 0));
      chk(32'(st[`FCS_ST_ERASING]), 32'h1);
      cmd(fcs_pkg::OP_ADDS, a, 8'h0);
      stc(stv(1, 0, 0, 1, 0));
      cmd(fcs_pkg::OP_SUSP, a, 8'h0);
      stc(stv(1, 0, 0, 0, 1));
      cmd(fcs_pkg::OP_RESET, a, 8'h0);
      stc(stv(1, 0, 1, 0, 1));
      cmd(fcs_pkg::OP_PROG, b, d);
      stc(stv(1, 0, 0, 0, 1));
      rda(b, d);
      cmd(fcs_pkg::OP_RESUM, a, 8'h0);
      cmd(fcs_pkg::OP_POLL, a, 8'h0);
      stc(stv(1, 0, 0, 0, 0));
      chk(32'(st[`FCS_ST_ERASING]), 32'h0);
      rda(a, 8'hff);
      rda(b, d);
      $display("suspend test done");
      cmd(fcs_pkg::OP_SECT, b, 8'h0);
      repeat (3100) @(posedge sys_clk);
      stc(stv(1, 0, 0, 0, 0));
      cmd(fcs_pkg::OP_POLL, b, 8'h0);
      rda(b, 8'hff);
      failTime <= 1;
      cmd(fcs_pkg::OP_CHIP, a, 8'h0);
      stc(stv(1, 1, 0, 0, 0));
      failTime <= 0;
      rda(b, 8'hff);
      apb(0, 8'h20, 32'h0, rd);
      chk(rd | {31'h0, er}, 32'h1);
      $display("window and failure test done");
      summarize();
   end
endmodule
`default_nettype wire
